// file: pkg/nvac_cfg.svh
// Constants of the data EEPROM access controller: offsets, bit positions, keys, timing.
// Assumes inclusion by bare name from the package file; the design module uses its macros without including it.
// Behaviour
// - An 8-bit address picks one of 256 bytes, 00h to FFh.
// - Control bit 7 clear selects data EEPROM, set selects program memory.
// - Control bit 6 set targets configuration registers; clear defers to bit 7.
// - Write enable, control bit 2, clears at power-up; only software changes it.
// - Abort flag, bit 3, sets at write start, clears on timed completion.
// - Software may set write-start, bit 1, but only hardware clears it.
// - Write completion clears write-start and sets a sticky done flag.
// - Read-start, bit 0, is ignored while program memory is selected.
// - A started read puts the byte in the data register next cycle.
// - The data register keeps a read byte until another read or write.
// - The unlock key location stores nothing and always reads zero.
// - Write starts only after 55h then AAh to the key, then write-start.
// - Write-start cannot be set unless write enable is already set.
// - Setting write enable and write-start together does not start a write.
// - During a write, control, address and data registers are frozen.
// - Each byte write erases the location, then programs it, timed internally.
// - A write error still loads both space select bits from the written byte.
// - With protection on, external reads and writes are refused.
`ifndef NVAC_CFG_SVH
`define NVAC_CFG_SVH
`define NVAC_OFF_CONTROL 3'h0
`define NVAC_OFF_KEY 3'h1
`define NVAC_OFF_ADDRESS 3'h2
`define NVAC_OFF_DATA 3'h3
`define NVAC_OFF_DONE 3'h4
`define NVAC_KEY_FIRST 8'h55
`define NVAC_KEY_SECOND 8'hAA
`define NVAC_CLK_PERIOD_NS 32'd10
`define NVAC_WRITE_TIME_NS 32'd4000000
`define NVAC_BIT_MSS 7
`define NVAC_BIT_CSS 6
`define NVAC_BIT_ABORT 3
`define NVAC_BIT_WRITE_UNLOCK_ENABLE 2
`define NVAC_BIT_WR 1
`define NVAC_BIT_RD 0
`define NVAC_BIT_DONE 0
`endif

// file: pkg/nvac_pkg.sv
// Types shared by the data EEPROM access controller.
// Assumes nvac_cfg.svh is on the include path.
`include "nvac_cfg.svh"
package nvac_pkg;
  // Register bus request carried as one bundle.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } nvac_bus_t;

  // Writable control bits as kept in flip-flops.
  typedef struct packed {
    logic mss;
    logic css;
    logic abort;
    logic write_unlock_enable;
    logic wr;
  } nvac_ctrl_t;

  // Write sequencer states, one-hot.
  typedef enum logic [2:0] {
    NVAC_IDLE = 3'b001,
    NVAC_ERASE = 3'b010,
    NVAC_PROG = 3'b100
  } nvac_state_t;

  // Unlock tracker states, one-hot.
  typedef enum logic [2:0] {
    NVAC_LOCKED = 3'b001,
    NVAC_KEY1 = 3'b010,
    NVAC_KEY2 = 3'b100
  } nvac_key_t;
endpackage : nvac_pkg

// file: verilog/nvac_ctrl.sv
// Data EEPROM access controller: registers, unlock tracker, self-timed writer, array.
// Assumes one 100 MHz clock, a register master on the same clock and a same-clock
// protection level and external-access qualifier.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
module nvac_ctrl
  import nvac_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int WRITE_CYCLES = `NVAC_WRITE_TIME_NS / `NVAC_CLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire nvac_bus_t bus,
  input wire logic ext_access,
  input wire logic code_protect,
  output logic [7:0] rdata_ff,
  output logic write_busy,
  output logic done_flag
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // Register hit for one strobe at one offset.
  function automatic logic hit(input logic strobe, input logic [2:0] a,
                               input logic [2:0] off);
    hit = strobe && (a == off);
  endfunction : hit

  nvac_ctrl_t ctrl_ff;
  nvac_state_t state_ff;
  nvac_key_t key_ff;
  logic [7:0] addr_ff;
  logic [7:0] data_ff;
  logic done_ff;
  logic [31:0] timer_ff;
  logic [7:0] mem [0:DEPTH-1];
  logic busy;
  logic refused;
  logic wr_ctrl;
  logic wr_key;
  logic to_eeprom;
  logic start;
  logic rd_start;
  logic phase_end;
  logic finish;

  // Protected array: external masters get neither reads nor writes.
  assign refused = ext_access && code_protect;
  assign busy = (state_ff != NVAC_IDLE);
  assign wr_ctrl = hit(bus.wr, bus.addr, `NVAC_OFF_CONTROL) && !busy;
  assign wr_key = hit(bus.wr, bus.addr, `NVAC_OFF_KEY);
  // Only the data array with configuration space off is served.
  assign to_eeprom = !bus.wdata[`NVAC_BIT_MSS] && !bus.wdata[`NVAC_BIT_CSS];
  // The enable must already be set, and the key pair must just precede.
  assign start = wr_ctrl && bus.wdata[`NVAC_BIT_WR] && ctrl_ff.write_unlock_enable
                 && (key_ff == NVAC_KEY2) && to_eeprom && !refused;
  // Read-start never latches: the byte is fetched on the strobe edge.
  assign rd_start = wr_ctrl && bus.wdata[`NVAC_BIT_RD] && to_eeprom && !refused;
  assign phase_end = (timer_ff == 32'(WRITE_CYCLES / 2 - 1));
  assign finish = (state_ff == NVAC_PROG) && phase_end;
  assign write_busy = busy;
  assign done_flag = done_ff;

  // ----------------------------------------------------------------
  // Unlock tracker
  // ----------------------------------------------------------------

  // Any bus write that breaks the exact 55h, AAh, start order relocks, except a 55h key write, which restarts the tracker at its first key.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      key_ff <= NVAC_LOCKED;
    end else if (bus.wr) begin
      if (wr_key && bus.wdata == `NVAC_KEY_FIRST) begin
        key_ff <= NVAC_KEY1;
      end else if (wr_key && bus.wdata == `NVAC_KEY_SECOND && key_ff == NVAC_KEY1) begin
        key_ff <= NVAC_KEY2;
      end else begin
        key_ff <= NVAC_LOCKED;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------

  // Software owns the enable and selects; hardware owns start and abort.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= '0;
    end else if (finish) begin
      ctrl_ff.wr <= 1'b0;
      ctrl_ff.abort <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_ff.mss <= bus.wdata[`NVAC_BIT_MSS];
      ctrl_ff.css <= bus.wdata[`NVAC_BIT_CSS];
      ctrl_ff.write_unlock_enable <= bus.wdata[`NVAC_BIT_WRITE_UNLOCK_ENABLE];
      if (start) begin
        ctrl_ff.wr <= 1'b1;
        ctrl_ff.abort <= 1'b1;
      end else if (bus.wdata[`NVAC_BIT_WR]) begin
        // An improper start attempt is recorded; selects stay for tracing.
        ctrl_ff.abort <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address and data registers
  // ----------------------------------------------------------------

  // Address is frozen while a write runs.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_ff <= 8'h00;
    end else if (hit(bus.wr, bus.addr, `NVAC_OFF_ADDRESS) && !busy) begin
      addr_ff <= bus.wdata;
    end
  end

  // Data holds the last fetched byte until the next read or software write.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_ff <= 8'h00;
    end else if (rd_start) begin
      data_ff <= mem[addr_ff];
    end else if (hit(bus.wr, bus.addr, `NVAC_OFF_DATA) && !busy) begin
      data_ff <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed writer
  // ----------------------------------------------------------------

  // Erase half, then program half; the timer restarts between phases.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= NVAC_IDLE;
      timer_ff <= 32'h0;
    end else begin
      case (state_ff)
        NVAC_IDLE: begin
          timer_ff <= 32'h0;
          if (start) begin
            state_ff <= NVAC_ERASE;
          end
        end
        NVAC_ERASE: begin
          timer_ff <= phase_end ? 32'h0 : timer_ff + 32'h1;
          if (phase_end) begin
            state_ff <= NVAC_PROG;
          end
        end
        NVAC_PROG: begin
          timer_ff <= phase_end ? 32'h0 : timer_ff + 32'h1;
          if (phase_end) begin
            state_ff <= NVAC_IDLE;
          end
        end
        default: begin
          state_ff <= NVAC_IDLE;
          timer_ff <= 32'h0;
        end
      endcase
    end
  end

  // The array has no reset; erase leaves all ones, programming the new byte.
  always_ff @(posedge mclk) begin
    if (state_ff == NVAC_ERASE && phase_end) begin
      mem[addr_ff] <= 8'hFF;
    end else if (finish) begin
      mem[addr_ff] <= data_ff;
    end
  end

  // ----------------------------------------------------------------
  // Done flag
  // ----------------------------------------------------------------

  // Sticky; software writes zero to clear, but a completion in the same
  // cycle wins so that no event is lost.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done_ff <= 1'b0;
    end else if (finish) begin
      done_ff <= 1'b1;
    end else if (hit(bus.wr, bus.addr, `NVAC_OFF_DONE) && !bus.wdata[`NVAC_BIT_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `NVAC_OFF_CONTROL: rdata_ff <= {ctrl_ff.mss, ctrl_ff.css, 2'b00, ctrl_ff.abort,
                                        ctrl_ff.write_unlock_enable, ctrl_ff.wr, 1'b0};
        `NVAC_OFF_ADDRESS: rdata_ff <= addr_ff;
        `NVAC_OFF_DATA: rdata_ff <= data_ff;
        `NVAC_OFF_DONE: rdata_ff <= {7'h00, done_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_wr_needs_key: assert property (start |-> key_ff == NVAC_KEY2 && ctrl_ff.write_unlock_enable)
    else $error("write started without unlock");
  a_write_unlock_enable_hw_keep: assert property (!wr_ctrl |=> $stable(ctrl_ff.write_unlock_enable))
    else $error("write enable changed by hardware");
  a_start_sets: assert property (start |=> ctrl_ff.wr && ctrl_ff.abort && busy)
    else $error("start did not set write and abort bits");
  a_wr_sw_clr: assert property (ctrl_ff.wr && !finish |=> ctrl_ff.wr)
    else $error("write-start cleared early");
  a_done_sets: assert property (finish |=> done_ff && !ctrl_ff.wr && !ctrl_ff.abort)
    else $error("completion not flagged");
  a_rd_ignored: assert property (wr_ctrl && bus.wdata[`NVAC_BIT_MSS] |-> !rd_start)
    else $error("read-start accepted for program memory");
  a_rd_next: assert property (rd_start |=> data_ff == mem[$past(addr_ff)])
    else $error("read byte not in data register");
  a_key_zero: assert property (hit(bus.rd, bus.addr, `NVAC_OFF_KEY) |=> rdata_ff == 8'h00)
    else $error("key location read nonzero");
  a_frozen: assert property (busy |=> $stable(addr_ff) && $stable(ctrl_ff.write_unlock_enable))
    else $error("registers changed during write");
  a_protect: assert property (refused |-> !start && !rd_start)
    else $error("protected access accepted");
  a_erase_first: assert property (state_ff == NVAC_ERASE && phase_end |=>
                                  state_ff == NVAC_PROG)
    else $error("program did not follow erase");

  // ----------------------------------------------------------------
  // Further checks
  // ----------------------------------------------------------------

  // These guard the corners that register traffic rarely reaches,
  // such as a completion that meets a software clear in one cycle.

  // A clear that meets a completion must lose, or the event is lost.
  // Software then sees the flag and can still clear it afterwards.
  a_done_wins: assert property (finish && hit(bus.wr, bus.addr, `NVAC_OFF_DONE) |=> done_ff)
    else $error("done flag lost to a clear");

  // Without a clear the flag stays, whatever else the bus does.
  // Polling software relies on this to catch a short write.
  a_done_sticky: assert property (done_ff && !hit(bus.wr, bus.addr, `NVAC_OFF_DONE) |=> done_ff)
    else $error("done flag dropped by hardware");

  // A refused start leaves a trace in the abort flag and starts nothing.
  // The selects are kept so software can see which space it aimed at.
  a_bad_start_abort: assert property (wr_ctrl && bus.wdata[`NVAC_BIT_WR] && !start |=>
                                      ctrl_ff.abort && !busy)
    else $error("improper start not recorded");

  // Enable and start in one write must not begin a write.
  // The enable has to come from an earlier, separate control write.
  a_same_write: assert property (wr_ctrl && bus.wdata[`NVAC_BIT_WR] && !ctrl_ff.write_unlock_enable |=>
                                 !busy)
    else $error("write began without prior enable");

  // The space selects stay put for the whole write.
  // A failing access can thus be traced after the event.
  a_sel_kept: assert property (busy |=> $stable(ctrl_ff.mss) && $stable(ctrl_ff.css))
    else $error("space selects changed during write");

  // The data byte being programmed must not move under the writer.
  // Both a software write and a read fetch are blocked while busy.
  a_data_frozen: assert property (busy |=> $stable(data_ff))
    else $error("data register changed during write");

  // Read data stand one cycle only, then the port returns zero.
  // A master that samples late sees zero rather than stale data.
  a_rd_idle_zero: assert property (!bus.rd |=> rdata_ff == 8'h00)
    else $error("read port not zero when idle");

  // The read-start bit never reads back as set.
  // It self-clears at once because the fetch takes a single edge.
  a_rd_bit_zero: assert property (hit(bus.rd, bus.addr, `NVAC_OFF_CONTROL) |=> !rdata_ff[0])
    else $error("read-start bit read back set");

  // The erase phase leaves the addressed byte all ones.
  // Programming then only has to clear the bits that need it.
  a_erase_ff: assert property (state_ff == NVAC_ERASE && phase_end |=>
                               mem[$past(addr_ff)] == 8'hFF)
    else $error("erase did not leave all ones");

  // The program phase stores the byte held in the data register.
  // The address and data are both frozen, so the past values are exact.
  a_prog_val: assert property (finish |=> mem[$past(addr_ff)] == $past(data_ff))
    else $error("programmed byte differs from data register");

  // The phase timer never runs past its terminal count.
  // An overrun would stretch the write without bound.
  a_busy_len: assert property (busy |-> timer_ff <= 32'(WRITE_CYCLES / 2 - 1))
    else $error("write timer overran its phase");

  // Any bus write other than a key write relocks the tracker.
  // This includes the start write itself, so each byte needs new keys.
  a_key_relock: assert property (bus.wr && !wr_key |=> key_ff == NVAC_LOCKED)
    else $error("unlock survived a foreign write");

  // Completion returns the writer to idle on the next edge.
  // Software may then start the next byte straight away.
  a_finish_idle: assert property (finish |=> state_ff == NVAC_IDLE)
    else $error("writer not idle after completion");

  // Configuration space is not served by this block.
  // Both start bits are ignored while its select is written set.
  a_cfg_refused: assert property (wr_ctrl && bus.wdata[`NVAC_BIT_CSS] |-> !start && !rd_start)
    else $error("start accepted for configuration space");

  // A write only ever begins aimed at the data array.
  // Program memory writes are outside this block.
  a_start_eeprom: assert property (start |-> !bus.wdata[`NVAC_BIT_MSS])
    else $error("write started for program memory");

  // The enable follows software writes and nothing else.
  // Hardware never clears it, not even at completion.
  a_write_unlock_enable_sw: assert property (wr_ctrl |=> ctrl_ff.write_unlock_enable == $past(bus.wdata[`NVAC_BIT_WRITE_UNLOCK_ENABLE]))
    else $error("write enable not taken from software");

  c_read: cover property (rd_start ##1 bus.rd);
  c_write: cover property (start ##[1:8] busy);
  c_done_clear_race: cover property (finish && hit(bus.wr, bus.addr, `NVAC_OFF_DONE));
  c_bad_start: cover property (wr_ctrl && bus.wdata[`NVAC_BIT_WR] && !start);
  c_protect: cover property (refused && wr_ctrl);

endmodule : nvac_ctrl

// file: bench/tb.sv
// Self-checking bench for the data EEPROM access controller.
// Assumes nvac_pkg and nvac_ctrl are compiled first; one 100 MHz clock drives all.
`timescale 1ns/1ns
module tb;
  import nvac_pkg::*;
  localparam int WCYC = 8; // Shortened write time keeps the run brief.
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  nvac_bus_t bus = '0;
  logic ext_access = 1'b0;
  logic code_protect = 1'b0;
  logic [7:0] rdata_ff;
  logic write_busy;
  logic done_flag;
  int fails = 0;
  int num_checks = 0;
  int busy_cnt = 0;
  logic [7:0] v;

  nvac_ctrl #(.WRITE_CYCLES(WCYC)) DUT (.mclk(mclk), .resetn(resetn), .bus(bus),
    .ext_access(ext_access), .code_protect(code_protect), .rdata_ff(rdata_ff),
    .write_busy(write_busy), .done_flag(done_flag));

  // Free-running clock, 10 ns period.
  always #5 mclk = ~mclk;

  // Busy length is counted here so register traffic may run during a write.
  always @(posedge mclk) begin
    if (write_busy === 1'b1) busy_cnt++;
  end

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One write strobe; the release lands on the next edge, never in the same step.
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 d = rdata_ff;
  endtask : reg_rd

  // No other traffic is interleaved, as an interrupt-free sequence would be.
  task automatic unlock_start(input logic [7:0] ctl);
    reg_wr(3'h1, 8'h55);
    reg_wr(3'h1, 8'hAA);
    reg_wr(3'h0, ctl);
    #1;
  endtask : unlock_start

  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    reg_wr(3'h2, a);
    reg_wr(3'h3, d);
    reg_wr(3'h0, 8'h04);
    busy_cnt = 0;
    unlock_start(8'h06);
    chk("busy at start", 8'h01, {7'h0, write_busy});
  endtask : write_byte

  task automatic wait_idle();
    for (int i = 0; i < 4 * WCYC && write_busy !== 1'b0; i++) @(posedge mclk);
    #1 chk("busy after write", 8'h00, {7'h0, write_busy});
  endtask : wait_idle

  task automatic read_byte(input logic [7:0] a, input logic [7:0] exp);
    reg_wr(3'h2, a);
    reg_wr(3'h0, 8'h01);
    reg_rd(3'h3, v);
    chk("read byte", exp, v);
  endtask : read_byte

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    for (int i = 0; i < 5; i++) begin
      reg_rd(i[2:0], v);
      chk("reset register", 8'h00, v);
    end
    reg_wr(3'h1, 8'h55);
    reg_rd(3'h1, v);
    chk("key readback", 8'h00, v);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_refused();
    reg_wr(3'h0, 8'h00);
    unlock_start(8'h06);
    chk("busy write_unlock_enable same write", 8'h00, {7'h0, write_busy});
    reg_wr(3'h0, 8'h81);
    reg_rd(3'h0, v);
    chk("read start in program space", 8'h80, v & 8'h81);
    reg_wr(3'h0, 8'h04);
    reg_wr(3'h1, 8'hAA);
    reg_wr(3'h1, 8'h55);
    reg_wr(3'h0, 8'h06);
    #1 chk("busy wrong key order", 8'h00, {7'h0, write_busy});
    reg_rd(3'h0, v);
    chk("abort after bad start", 8'h08, v & 8'h0A);
    reg_wr(3'h0, 8'hC4);
    unlock_start(8'hC6);
    reg_rd(3'h0, v);
    chk("space bits kept", 8'hC0, v & 8'hC2);
    $display("test_refused done");
  endtask : test_refused

  task automatic test_write();
    write_byte(8'h5A, 8'h3C);
    reg_rd(3'h0, v);
    chk("control while busy", 8'h0E, v);
    reg_wr(3'h2, 8'h00);
    wait_idle();
    chk("busy length", 8'(WCYC), busy_cnt[7:0]);
    reg_rd(3'h0, v);
    chk("control after write", 8'h04, v);
    reg_rd(3'h2, v);
    chk("address frozen", 8'h5A, v);
    reg_rd(3'h4, v);
    chk("done register", 8'h01, v);
    chk("done flag", 8'h01, {7'h0, done_flag});
    reg_wr(3'h4, 8'h00);
    #1 chk("done cleared", 8'h00, {7'h0, done_flag});
    write_byte(8'hFF, 8'hA5);
    wait_idle();
    read_byte(8'hFF, 8'hA5);
    read_byte(8'h5A, 8'h3C);
    reg_rd(3'h3, v);
    chk("data held", 8'h3C, v);
    $display("test_write done");
  endtask : test_write

  task automatic test_protect();
    reg_wr(3'h3, 8'h11);
    @(posedge mclk);
    ext_access <= 1'b1;
    code_protect <= 1'b1;
    reg_wr(3'h0, 8'h01);
    reg_rd(3'h3, v);
    chk("external read refused", 8'h11, v);
    @(posedge mclk);
    ext_access <= 1'b0;
    read_byte(8'h5A, 8'h3C);
    $display("test_protect done");
  endtask : test_protect

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // Reset is held for eight edges before the first request.
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    test_reset();
    test_refused();
    test_write();
    test_protect();
    complete_run();
  end

  // The whole sequence needs under two hundred cycles; this limit is ample.
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    complete_run();
  end
endmodule : tb
